// ==== include/bsw_pkg.sv ====
package bsw_pkg;

    // Word width and bit positions of the block status word.
    localparam int W      = 16;
    localparam int B_EOM  = 15;
    localparam int B_SOM  = 14;
    localparam int B_BUS  = 13;
    localparam int B_EO   = 12;
    localparam int B_RTRT = 11;
    localparam int B_GAP  = 10;
    localparam int B_TMO  = 9;
    localparam int B_LEN  = 5;
    localparam int B_SYNC = 4;
    localparam int B_WORD = 3;
    localparam int B_RTE  = 2;
    localparam int B_CW2  = 1;
    localparam int B_CWC  = 0;

    localparam logic [W-1:0] BSW_RESET = 16'h0000;
    // Bits 10, 9, 5, 4, 3 and 2 always feed the summary fault flag.
    localparam logic [W-1:0] EO_MASK   = 16'h063C;

    // Command word fields.
    localparam int TR_BIT = 10;
    localparam int SA_HI  = 9;
    localparam int SA_LO  = 5;
    localparam int MC_HI  = 4;
    localparam int MC_LO  = 0;
    localparam int RTA_HI = 15;
    localparam int RTA_LO = 11;
    localparam logic [4:0] SA_MODE_LOW  = 5'h00;
    localparam logic [4:0] SA_MODE_HIGH = 5'h1F;
    localparam logic [4:0] MC_RX_LIMIT  = 5'h10;

    // Start flag delay: least 3 us, rounded up to whole cycles.
    localparam int CLK_PERIOD_NS   = 10;
    localparam int START_DELAY_NS  = 3000;
    localparam int START_DELAY_CYC =
        (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] START_CYC = CNT_W'(START_DELAY_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO  = 9'h000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 9'h001;
    localparam logic [CNT_W-1:0] CNT_MAX   = 9'h1FF;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_RUN  = 3'h4
    } mon_state_e;

endpackage

// ==== include/track_if.sv ====
`timescale 1ns/1ps
interface track_if import bsw_pkg::*; ();
    logic         arm;
    logic         expired;
    logic [W-1:0] cmd_new;
    logic [W-1:0] cmd_held;
    logic         undef_mode;
    logic         cw2_exempt;

    modport owner   (output arm, cmd_new, cmd_held,
                     input  expired, undef_mode, cw2_exempt);
    modport timer   (input  arm, output expired);
    modport decoder (input  cmd_new, cmd_held,
                     output undef_mode, cw2_exempt);
endinterface

// ==== hw/start_timer.sv ====
`timescale 1ns/1ps
module start_timer import bsw_pkg::*; (
    input  wire logic  clk,
    input  wire logic  rst,
    track_if.timer     trk
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // Load on arm, then count down to zero; arming again restarts it.
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (trk.arm)
            nxt_cnt = START_CYC;
        else if (cnt_ff != CNT_ZERO)
            nxt_cnt = cnt_ff - CNT_ONE;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            cnt_ff <= CNT_ZERO;
        else
            cnt_ff <= nxt_cnt;
    end

    // Expiry is seen in the last counted cycle so the flag lands on time.
    assign trk.expired = (cnt_ff == CNT_ONE);

    chk_timer_load: assert property (@(posedge clk) disable iff (rst)
        trk.arm |=> cnt_ff == START_CYC)
        else $error("start timer did not load its delay");
    cov_timer_expire: cover property (@(posedge clk) disable iff (rst)
        trk.expired);
endmodule

// ==== hw/cmd_check.sv ====
`timescale 1ns/1ps
module cmd_check import bsw_pkg::*; (
    input  wire logic  clk,
    input  wire logic  rst,
    track_if.decoder   trk
);
    logic [4:0] sa_new;
    logic [4:0] mc_new;

    assign sa_new = trk.cmd_new[SA_HI:SA_LO];
    assign mc_new = trk.cmd_new[MC_HI:MC_LO];

    // Decode the incoming command against the held first command.
    always_comb
    begin
        trk.undef_mode = !trk.cmd_new[TR_BIT]
            && (sa_new == SA_MODE_LOW || sa_new == SA_MODE_HIGH)
            && (mc_new < MC_RX_LIMIT);
        trk.cw2_exempt = (sa_new == SA_MODE_LOW)
            || (sa_new == SA_MODE_HIGH)
            || (trk.cmd_new[RTA_HI:RTA_LO]
                == trk.cmd_held[RTA_HI:RTA_LO]);
    end

    chk_same_address: assert property (@(posedge clk) disable iff (rst)
        trk.cmd_new[RTA_HI:RTA_LO] == trk.cmd_held[RTA_HI:RTA_LO]
        |-> trk.cw2_exempt)
        else $error("same terminal address not exempted");
endmodule

// ==== hw/bsw_builder.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Set end flag when message completes.
// - Clear start flag when end flag sets.
// - Set start flag 3-4 us after command.
// - Filtered-out messages never get start flag.
// - Bus bit: 0 for bus A, 1 for B.
// - Superseded unfinished message sets summary fault.
// - Gap, timeout, count errors set summary fault.
// - Sync, invalid word, RT-RT errors set fault.
// - Bits 1 and 0 normally set fault.
// - Mode subaddress in command two: no fault.
// - Same address in command two: no fault.
// - Undefined receive mode code: bit 0 only.
// - Two contiguous commands mark RT-RT transfer.
module bsw_builder import bsw_pkg::*; (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         filter_enable,
    input  wire logic         cmd_valid,
    input  wire logic [W-1:0] cmd_word,
    input  wire logic         cmd_on_bus_b,
    input  wire logic         cmd_contiguous,
    input  wire logic         cmd_selected,
    input  wire logic         msg_complete,
    input  wire logic         gap_error,
    input  wire logic         timeout_error,
    input  wire logic         count_error,
    input  wire logic         sync_error,
    input  wire logic         word_error,
    input  wire logic         rtrt_error,
    input  wire logic         cw2_error,
    input  wire logic         content_error,
    output logic [W-1:0]      block_status_word,
    output logic              stack_write,
    output logic [W-1:0]      stack_data
);
    mon_state_e       state_ff;
    mon_state_e       nxt_state;
    logic [W-1:0]     bsw_ff;
    logic [W-1:0]     nxt_bsw;
    logic [W-1:0]     cmd1_ff;
    logic [W-1:0]     nxt_cmd1;
    logic             rtrt_ff;
    logic             nxt_rtrt;
    logic             sel_ff;
    logic             nxt_sel;
    logic             wr_ff;
    logic             nxt_wr;
    logic [W-1:0]     data_ff;
    logic [W-1:0]     nxt_data;
    logic [W-1:0]     err_bits;
    logic             is_open;
    logic             take_new;
    logic             finish;
    logic [W-1:0]     word;
    logic [CNT_W-1:0] age_ff;

    track_if trk ();

    start_timer u_timer (
        .clk (clk),
        .rst (rst),
        .trk (trk)
    );

    cmd_check u_check (
        .clk (clk),
        .rst (rst),
        .trk (trk)
    );

    assign trk.cmd_new  = cmd_word;
    assign trk.cmd_held = cmd1_ff;
    assign is_open      = (state_ff == ST_WAIT) || (state_ff == ST_RUN);

    // Error events only count while a message is open, filtered or not.
    always_comb
    begin
        err_bits         = BSW_RESET;
        err_bits[B_GAP]  = is_open && gap_error;
        err_bits[B_TMO]  = is_open && timeout_error;
        err_bits[B_LEN]  = is_open && count_error;
        err_bits[B_SYNC] = is_open && sync_error;
        err_bits[B_WORD] = is_open && word_error;
        err_bits[B_RTE]  = is_open && rtrt_error;
        err_bits[B_CW2]  = is_open && cw2_error;
        err_bits[B_CWC]  = is_open && content_error;
    end

    // Message tracking. Flags set by hardware are sticky until the next message starts,
    // except the start flag, which clears when the end flag sets; events between messages are dropped.
    always_comb
    begin
        nxt_state = state_ff;
        nxt_bsw   = bsw_ff;
        nxt_cmd1  = cmd1_ff;
        nxt_rtrt  = rtrt_ff;
        nxt_sel   = sel_ff;
        nxt_wr    = 1'b0;
        nxt_data  = data_ff;
        trk.arm   = 1'b0;
        take_new  = 1'b0;
        finish    = 1'b0;
        word      = bsw_ff | err_bits;
        // gap, timeout, count, sync, word, RT-RT errors feed fault
        if (|(word & EO_MASK))
            word[B_EO] = 1'b1;
        // plain bit 1 or 0 errors feed fault
        if (is_open && (cw2_error || content_error))
            word[B_EO] = 1'b1;
        case (state_ff)
            ST_IDLE:
            begin
                take_new = cmd_valid;
            end
            ST_WAIT, ST_RUN:
            begin
                if (cmd_valid && cmd_contiguous && !rtrt_ff)
                begin
                    word[B_RTRT] = 1'b1;
                    nxt_rtrt     = 1'b1;
                    if (trk.cw2_exempt)
                        word[B_CW2] = 1'b1;
                end
                else if (cmd_valid)
                begin
                    // old message overtaken unless it just ended
                    if (!msg_complete)
                        word[B_EO] = 1'b1;
                    finish   = 1'b1;
                    take_new = 1'b1;
                end
                else if (msg_complete)
                begin
                    finish    = 1'b1;
                    nxt_state = ST_IDLE;
                end
                if (state_ff == ST_WAIT && trk.expired && !finish)
                begin
                    nxt_state = ST_RUN;
                    if (sel_ff)
                        word[B_SOM] = 1'b1;
                end
                if (finish)
                begin
                    word[B_EOM] = 1'b1;
                    word[B_SOM] = 1'b0;
                end
                nxt_bsw = word;
                // record changes and the final word
                if (sel_ff && (finish || word != bsw_ff))
                begin
                    nxt_wr   = 1'b1;
                    nxt_data = word;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
        // A new command opens a fresh word and restarts the delay.
        if (take_new)
        begin
            nxt_state      = ST_WAIT;
            nxt_bsw        = BSW_RESET;
            nxt_bsw[B_BUS] = cmd_on_bus_b;
            nxt_bsw[B_CWC] = trk.undef_mode;
            nxt_cmd1       = cmd_word;
            nxt_rtrt       = 1'b0;
            nxt_sel        = !filter_enable || cmd_selected;
            trk.arm        = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
            bsw_ff   <= BSW_RESET;
            cmd1_ff  <= BSW_RESET;
            rtrt_ff  <= 1'b0;
            sel_ff   <= 1'b0;
            wr_ff    <= 1'b0;
            data_ff  <= BSW_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
            bsw_ff   <= nxt_bsw;
            cmd1_ff  <= nxt_cmd1;
            rtrt_ff  <= nxt_rtrt;
            sel_ff   <= nxt_sel;
            wr_ff    <= nxt_wr;
            data_ff  <= nxt_data;
        end
    end

    // Outputs come straight from the registers above.
    assign block_status_word = bsw_ff;
    assign stack_write       = wr_ff;
    assign stack_data        = data_ff;

    // Cycles since the last arm; read only by the checks below.
    always_ff @(posedge clk)
    begin
        if (rst)
            age_ff <= CNT_ZERO;
        else if (trk.arm)
            age_ff <= CNT_ZERO;
        else if (age_ff != CNT_MAX)
            age_ff <= age_ff + CNT_ONE;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_end_sets_flag: assert property (
        is_open && msg_complete && !cmd_valid && sel_ff
        |=> stack_write && stack_data[B_EOM] && state_ff == ST_IDLE)
        else $error("message end did not write end flag");
    chk_end_clears_start: assert property (
        stack_write && stack_data[B_EOM] |-> !stack_data[B_SOM])
        else $error("start flag left set with end flag");
    chk_start_delay: assert property (
        $rose(bsw_ff[B_SOM]) |-> age_ff == START_CYC)
        else $error("start flag not set at the delay");
    chk_start_filtered: assert property (
        bsw_ff[B_SOM] |-> sel_ff)
        else $error("start flag set for filtered message");
    chk_bus_identity: assert property (
        state_ff == ST_IDLE && cmd_valid
        |=> bsw_ff[B_BUS] == $past(cmd_on_bus_b))
        else $error("bus bit does not match the bus");
    chk_supersede_fault: assert property (
        is_open && cmd_valid && !cmd_contiguous && !msg_complete && sel_ff
        |=> stack_write && stack_data[B_EO] && stack_data[B_EOM])
        else $error("superseded message not flagged");
    chk_fault_summary: assert property (
        stack_write && (|(stack_data & EO_MASK)) |-> stack_data[B_EO])
        else $error("error bit without summary fault");
    chk_cw2_fault: assert property (
        is_open && cw2_error && !cmd_valid |=> bsw_ff[B_EO])
        else $error("plain bit 1 error missed summary fault");
    chk_cw2_exempt: assert property (
        is_open && cmd_valid && cmd_contiguous && !rtrt_ff
        && trk.cw2_exempt && !bsw_ff[B_EO] && err_bits == BSW_RESET
        |=> bsw_ff[B_CW2] && !bsw_ff[B_EO])
        else $error("exempt second command raised fault");
    chk_undef_mode: assert property (
        state_ff == ST_IDLE && cmd_valid && trk.undef_mode
        |=> bsw_ff[B_CWC] && !bsw_ff[B_EO])
        else $error("undefined mode code handled wrongly");
    chk_rtrt_mark: assert property (
        is_open && cmd_valid && cmd_contiguous && !rtrt_ff
        |=> bsw_ff[B_RTRT] && rtrt_ff)
        else $error("RT-RT transfer not marked");

    // These watch the live word, filtered messages included, because the
    // host may read it before any stack write for the message lands.
    chk_gap_fault: assert property (
        is_open && !cmd_valid
        && (gap_error || timeout_error || count_error)
        |=> bsw_ff[B_EO])
        else $error("gap timeout or count error without fault");
    chk_sync_fault: assert property (
        is_open && !cmd_valid
        && (sync_error || word_error || rtrt_error)
        |=> bsw_ff[B_EO])
        else $error("sync word or RT-RT error without fault");
    chk_same_rt_exempt: assert property (
        is_open && cmd_valid && cmd_contiguous && !rtrt_ff
        && cmd_word[RTA_HI:RTA_LO] == cmd1_ff[RTA_HI:RTA_LO]
        && !bsw_ff[B_EO] && err_bits == BSW_RESET
        |=> bsw_ff[B_CW2] && !bsw_ff[B_EO])
        else $error("same terminal address raised fault");
    chk_fault_sticky: assert property (
        is_open && bsw_ff[B_EO] && !cmd_valid |=> bsw_ff[B_EO])
        else $error("summary fault lost inside a message");
    chk_end_live_word: assert property (
        is_open && msg_complete && !cmd_valid
        |=> bsw_ff[B_EOM] && !bsw_ff[B_SOM])
        else $error("live word not closed at message end");
    chk_word_recorded: assert property (
        stack_write && !stack_data[B_EOM] |-> stack_data == bsw_ff)
        else $error("stack write differs from the live word");

    cov_normal_message: cover property (
        $rose(bsw_ff[B_SOM]) ##[1:1000] stack_write && stack_data[B_EOM]);
    cov_rtrt_message: cover property (
        $rose(rtrt_ff) ##[1:1000] stack_write && stack_data[B_EOM]);
    cov_superseded: cover property (
        is_open && cmd_valid && !cmd_contiguous && !msg_complete);

    // A filtered-out message that still runs to its end.
    cov_filtered_message: cover property (
        filter_enable && is_open && !sel_ff && msg_complete);
endmodule

// ==== test/bus_source.sv ====
`timescale 1ns/1ps
// Stands for the observed dual bus: it reports command words, message
// ends and error pulses the way the front end would deliver them.
module bus_source import bsw_pkg::*; (
    input  wire logic  clk,
    output logic       cmd_valid,
    output logic [W-1:0] cmd_word,
    output logic       cmd_on_bus_b,
    output logic       cmd_contiguous,
    output logic       cmd_selected,
    output logic       msg_complete,
    output logic [7:0] errs
);
    // Released qualifiers show the inverse of their last value, so that
    // a stale value can never be mistaken for a fresh one.
    initial
    begin
        cmd_valid = 1'b0;
        cmd_word = 16'h0000;
        cmd_on_bus_b = 1'b0;
        cmd_contiguous = 1'b0;
        cmd_selected = 1'b0;
        msg_complete = 1'b0;
        errs = 8'h00;
    end

    task automatic cmd(input logic [W-1:0] w, input logic b,
                       input logic c, input logic s);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        cmd_on_bus_b <= b;
        cmd_contiguous <= c;
        cmd_selected <= s;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_word <= ~w;
        cmd_on_bus_b <= ~b;
        cmd_contiguous <= ~c;
        cmd_selected <= ~s;
    endtask

    task automatic err(input int i);
        @(posedge clk);
        errs[i] <= 1'b1;
        @(posedge clk);
        errs <= 8'h00;
    endtask

    task automatic done();
        @(posedge clk);
        msg_complete <= 1'b1;
        @(posedge clk);
        msg_complete <= 1'b0;
    endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import bsw_pkg::*;;
    logic         clk;
    logic         rst;
    logic         filter_enable;
    logic         cv;
    logic [W-1:0] cw;
    logic         cb;
    logic         cc;
    logic         cs;
    logic         mc;
    logic [7:0]   errs;
    logic [W-1:0] bsw;
    logic         stack_write;
    logic [W-1:0] stack_data;
    logic [W-1:0] last_data;
    int           wr_cnt;
    int           mismatches;
    int           num_checks;
    int           pos[8];
    int           n;

    bus_source bus (.clk(clk), .cmd_valid(cv), .cmd_word(cw),
        .cmd_on_bus_b(cb), .cmd_contiguous(cc), .cmd_selected(cs),
        .msg_complete(mc), .errs(errs));

    bsw_builder uut (.clk(clk), .rst(rst), .filter_enable(filter_enable),
        .cmd_valid(cv), .cmd_word(cw), .cmd_on_bus_b(cb),
        .cmd_contiguous(cc), .cmd_selected(cs), .msg_complete(mc),
        .gap_error(errs[0]), .timeout_error(errs[1]),
        .count_error(errs[2]), .sync_error(errs[3]),
        .word_error(errs[4]), .rtrt_error(errs[5]), .cw2_error(errs[6]),
        .content_error(errs[7]), .block_status_word(bsw),
        .stack_write(stack_write), .stack_data(stack_data));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Stack writes are sampled on the falling edge, away from the update.
    always @(negedge clk)
    begin
        if (stack_write === 1'b1)
        begin
            wr_cnt++;
            last_data = stack_data;
        end
    end

    function automatic logic [W-1:0] b(input int i);
        return 16'h0001 << i;
    endfunction

    task automatic check(input string name, input logic [W-1:0] seen,
                         input logic [W-1:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Two edges pass so that a registered answer has surely landed.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // The longest path is two start delays plus short messages.
    initial
    begin
        #(20000 * 10);
        mismatches++;
        end_of_test();
    end

    initial
    begin
        rst = 1'b1;
        filter_enable = 1'b0;
        wr_cnt = 0;
        mismatches = 0;
        num_checks = 0;
        pos = '{B_GAP, B_TMO, B_LEN, B_SYNC, B_WORD, B_RTE, B_CW2, B_CWC};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("reset word", bsw, BSW_RESET);
        // Normal message on bus B, start flag timing and final word.
        bus.cmd(16'h2822, 1'b1, 1'b0, 1'b1);
        repeat (299) @(posedge clk);
        #1;
        check("start early", bsw, b(B_BUS));
        @(posedge clk);
        #1;
        check("start", bsw, b(B_SOM) | b(B_BUS));
        check("bus b", bsw & b(B_BUS), b(B_BUS));
        bus.done();
        settle();
        check("end word", bsw, b(B_EOM) | b(B_BUS));
        check("start cleared", bsw & b(B_SOM), 16'h0000);
        check("end stored", last_data, b(B_EOM) | b(B_BUS));
        // Every error source, each on its own message on bus A.
        for (int i = 0; i < 8; i++)
        begin
            bus.cmd(16'h2822, 1'b0, 1'b0, 1'b1);
            bus.err(i);
            settle();
            check("error word", bsw, b(pos[i]) | b(B_EO));
            bus.done();
            settle();
            check("error end", last_data,
                  b(B_EOM) | b(pos[i]) | b(B_EO));
        end
        // Undefined receive mode code sets bit 0 alone.
        bus.cmd(16'h2803, 1'b0, 1'b0, 1'b1);
        settle();
        check("mode code", bsw, b(B_CWC));
        bus.done();
        // Unfinished message superseded by a new command.
        bus.cmd(16'h2822, 1'b1, 1'b0, 1'b1);
        bus.cmd(16'h3022, 1'b0, 1'b0, 1'b1);
        settle();
        check("superseded", last_data,
              b(B_EOM) | b(B_BUS) | b(B_EO));
        check("new opened", bsw, 16'h0000);
        bus.done();
        // Exempt second commands: mode subaddress, then same address.
        bus.cmd(16'h2822, 1'b0, 1'b0, 1'b1);
        bus.cmd(16'h3C02, 1'b0, 1'b1, 1'b1);
        settle();
        check("rtrt mode sa", bsw, b(B_RTRT) | b(B_CW2));
        bus.done();
        bus.cmd(16'h2822, 1'b0, 1'b0, 1'b1);
        bus.cmd(16'h2C22, 1'b0, 1'b1, 1'b1);
        settle();
        check("rtrt same rt", bsw, b(B_RTRT) | b(B_CW2));
        bus.done();
        // Filtered-out traffic gets no start flag and no writes.
        settle();
        @(posedge clk);
        filter_enable <= 1'b1;
        n = wr_cnt;
        bus.cmd(16'h2822, 1'b1, 1'b0, 1'b0);
        repeat (310) @(posedge clk);
        #1;
        check("filtered start", bsw & b(B_SOM), 16'h0000);
        bus.done();
        settle();
        check("filtered writes", 16'(wr_cnt - n), 16'h0000);
        check("filtered end", bsw, b(B_EOM) | b(B_BUS));
        // With the filter on, a selected message is still recorded.
        n = wr_cnt;
        bus.cmd(16'h2822, 1'b0, 1'b0, 1'b1);
        bus.err(0);
        settle();
        check("selected write", last_data, b(B_GAP) | b(B_EO));
        check("selected count", 16'(wr_cnt - n), 16'h0001);
        bus.done();
        settle();
        check("selected end", last_data,
              b(B_EOM) | b(B_GAP) | b(B_EO));
        end_of_test();
    end
endmodule
